// ==== hdl/sarcc_fifo.v ====
`timescale 1ns/1ns
module sarcc_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             sys_clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    function [AW-1:0] inc_ptr;
        input [AW-1:0] p;
        begin
            inc_ptr = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data_i;
                wr_reg          <= inc_ptr(wr_reg);
            end
            if (pop)
                rd_reg <= inc_ptr(rd_reg);
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule // sarcc_fifo

// ==== hdl/sarcc_regs.vh ====
`ifndef SARCC_REGS_VH
`define SARCC_REGS_VH
// result format and conversion framing
`define SARCC_RES_W          14
`define SARCC_MSB_POS        13
`define SARCC_SAR_RESET      14'h0000
`define SARCC_MOST_NEG       14'h2000
// conversion time, typical 250 ns
`define SARCC_T_CONV_NS      250
`define SARCC_CLK_NS         10
`define SARCC_STEP_CYC       ((`SARCC_T_CONV_NS / `SARCC_CLK_NS) / `SARCC_RES_W)
// range codes: 0 with both selects high, 1 with only the low select high
`define SARCC_RANGE_0DB      2'h0
`define SARCC_RANGE_M3DB     2'h1
`define SARCC_RANGE_M6DB     2'h2
`define SARCC_RANGE_M9DB     2'h3
// fifo
`define SARCC_FIFO_DEPTH     4
`endif

// ==== hdl/sarcc_top.v ====
`timescale 1ns/1ns
`include "sarcc_regs.vh"
// How it works
// - falling start edge begins a conversion
// - start edges ignored while converting
// - busy low during conversion only
// - msb to lsb search, one comparator decision
// - finished word loaded into output latch
// - result bit 13 is msb
// - flag with msb tells over or under
// - two select inputs choose four ranges
// - nap low powers down conversion, keeps reference
// - sleep low gives deep shutdown
// - both inputs sampled at start instant
// - result is two's complement
// - data updates after busy rises
// - flag on most negative or overrange
module sarcc_top #(
    parameter RES_W    = `SARCC_RES_W,
    parameter STEP_CYC = `SARCC_STEP_CYC,
    parameter DEPTH    = `SARCC_FIFO_DEPTH
) (
    input  wire             sys_clk_i,
    input  wire             rst_i,
    input  wire             conversion_start_n_i,
    input  wire             comparator_high_i,
    input  wire             overrange_detect_i,
    input  wire             range_select_lo_i,
    input  wire             range_select_hi_i,
    input  wire             nap_shutdown_n_i,
    input  wire             deep_shutdown_n_i,
    input  wire             result_ready_i,
    output reg              busy_n_o,
    output reg  [RES_W-1:0] result_o,
    output reg              out_of_range_flag_o,
    output reg              sample_hold_o,
    output reg  [1:0]       range_code_o,
    output reg              nap_active_o,
    output reg              deep_active_o,
    output reg  [RES_W-1:0] dac_trial_o,
    output reg              fifo_full_o,
    output wire [RES_W:0]   fifo_data_o,
    output wire             fifo_valid_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_LOAD = 2'h2;
    localparam [RES_W-1:0] SIGN_TRIAL = {1'b1, {(RES_W-1){1'b0}}};

    // conversion state
    reg [1:0]        state_reg;
    reg [1:0]        state_next;
    reg              start_prev_reg;
    reg [RES_W-1:0]  sar_reg;
    reg [RES_W-1:0]  sar_next;
    reg [RES_W-1:0]  bit_reg;
    reg [RES_W-1:0]  bit_next;
    reg [7:0]        step_reg;
    reg [7:0]        step_next;
    reg              ovr_reg;
    reg              ovr_next;
    // result hand-off into the buffer
    reg              push_reg;
    reg              push_next;
    reg [RES_W:0]    push_data_reg;
    reg [RES_W:0]    push_data_next;
    // next values of the registered outputs
    reg              busy_n_next;
    reg [RES_W-1:0]  result_next;
    reg              flag_next;
    reg              sample_next;
    reg [RES_W-1:0]  dac_next;
    wire             fifo_in_ready;
    wire             start_edge;
    wire             shutdown;
    wire [RES_W-1:0] trial;
    wire [RES_W-1:0] sar_decided;

    // one decode for latch and buffer, so the two can never disagree
    function flag_of;
        input [RES_W-1:0] word;
        input             ovr;
        begin
            flag_of = (word == `SARCC_MOST_NEG) | ovr;
        end
    endfunction

    // a level held low never retriggers; only the high-to-low step counts
    assign start_edge  = start_prev_reg & ~conversion_start_n_i;
    assign shutdown    = ~nap_shutdown_n_i | ~deep_shutdown_n_i;
    assign trial       = sar_reg | bit_reg;
    // comparator high means input above trial level; msb weight is negative
    assign sar_decided = (bit_reg[RES_W-1] ^ comparator_high_i) ?
                         trial : sar_reg;

    // results wait here until drained; a full buffer refuses new starts
    sarcc_fifo #(
        .WIDTH (RES_W + 1),
        .DEPTH (DEPTH),
        .AW    (2)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (push_data_reg),
        .in_valid_i  (push_reg),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data_o),
        .out_valid_o (fifo_valid_o),
        .out_ready_i (result_ready_i)
    );

    // one decision per STEP_CYC cycles, sign bit first
    always @* begin
        state_next     = state_reg;
        sar_next       = sar_reg;
        bit_next       = bit_reg;
        step_next      = step_reg;
        ovr_next       = ovr_reg;
        busy_n_next    = busy_n_o;
        result_next    = result_o;
        flag_next      = out_of_range_flag_o;
        dac_next       = dac_trial_o;
        sample_next    = 1'b0;
        push_next      = 1'b0;
        push_data_next = push_data_reg;
        case (state_reg)
            ST_IDLE: begin
                busy_n_next = 1'b1;
                // ignore start edges while the buffer is full of unread results, back-pressure to host
                if (start_edge && !shutdown && fifo_in_ready) begin
                    sample_next = 1'b1;
                    busy_n_next = 1'b0;
                    sar_next    = `SARCC_SAR_RESET;
                    bit_next    = SIGN_TRIAL;
                    step_next   = 8'h00;
                    ovr_next    = 1'b0;
                    // dac must already show the sign trial at the first decision
                    dac_next    = SIGN_TRIAL;
                    state_next  = ST_CONV;
                end
            end
            ST_CONV: begin
                // start edges fall through here unseen
                if (step_reg == STEP_CYC[7:0] - 8'h01) begin
                    step_next = 8'h00;
                    sar_next  = sar_decided;
                    bit_next  = bit_reg >> 1;
                    // registered dac would lag a step if it copied the present trial
                    dac_next  = sar_decided | (bit_reg >> 1);
                    if (bit_reg[0]) begin
                        ovr_next    = overrange_detect_i;
                        busy_n_next = 1'b1;
                        state_next  = ST_LOAD;
                    end
                end else begin
                    step_next = step_reg + 8'h01;
                end
            end
            ST_LOAD: begin
                // data moves one cycle after busy rises
                result_next    = sar_reg;
                flag_next      = flag_of(sar_reg, ovr_reg);
                push_next      = 1'b1;
                push_data_next = {flag_of(sar_reg, ovr_reg), sar_reg};
                state_next     = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // busy, result, flag, sample and dac outputs are flops fed from the decoder above
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg           <= ST_IDLE;
            // high, so a pin already low at release is taken as an edge
            start_prev_reg      <= 1'b1;
            sar_reg             <= `SARCC_SAR_RESET;
            bit_reg             <= {RES_W{1'b0}};
            step_reg            <= 8'h00;
            ovr_reg             <= 1'b0;
            push_reg            <= 1'b0;
            push_data_reg       <= {(RES_W+1){1'b0}};
            busy_n_o            <= 1'b1;
            result_o            <= {RES_W{1'b0}};
            out_of_range_flag_o <= 1'b0;
            sample_hold_o       <= 1'b0;
            range_code_o        <= `SARCC_RANGE_0DB;
            nap_active_o        <= 1'b0;
            deep_active_o       <= 1'b0;
            dac_trial_o         <= {RES_W{1'b0}};
            fifo_full_o         <= 1'b0;
        end else begin
            state_reg           <= state_next;
            start_prev_reg      <= conversion_start_n_i;
            sar_reg             <= sar_next;
            bit_reg             <= bit_next;
            step_reg            <= step_next;
            ovr_reg             <= ovr_next;
            push_reg            <= push_next;
            push_data_reg       <= push_data_next;
            busy_n_o            <= busy_n_next;
            result_o            <= result_next;
            out_of_range_flag_o <= flag_next;
            sample_hold_o       <= sample_next;
            // select pins are plain levels, seen one cycle late
            range_code_o        <= {~range_select_lo_i, ~range_select_hi_i};
            nap_active_o        <= ~nap_shutdown_n_i;
            deep_active_o       <= ~deep_shutdown_n_i;
            dac_trial_o         <= dac_next;
            fifo_full_o         <= ~fifo_in_ready;
        end
    end
endmodule // sarcc_top

// ==== testbench/sarcc_host_model.sv ====
`timescale 1ns/1ns
module sarcc_host_model (
    input  wire [13:0] dac_trial_i,
    input  wire [13:0] target_i,
    input  wire        stall_i,
    output wire        comp_o,
    output wire        ready_o
);
    // sign step judges polarity, later steps the low-bit magnitude
    assign comp_o  = (dac_trial_i[12:0] == 13'h0) ? ~target_i[13]
                   : (target_i[12:0] >= dac_trial_i[12:0]);
    assign ready_o = ~stall_i;
endmodule // sarcc_host_model

// ==== testbench/sarcc_top_properties.sv ====
`timescale 1ns/1ns
module sarcc_top_properties #(parameter STEP_CYC = 1) (
    input wire        sys_clk_i, rst_i, busy_n_o, sample_hold_o, out_of_range_flag_o,
    input wire        range_select_lo_i, range_select_hi_i, nap_shutdown_n_i,
    input wire        deep_shutdown_n_i, nap_active_o, deep_active_o,
    input wire [13:0] result_o,
    input wire [1:0]  range_code_o
);
    reg [7:0] lo_cnt;
    // counts sampled busy-low cycles of the running conversion
    always @(posedge sys_clk_i)
        if (rst_i || busy_n_o) lo_cnt <= 8'h00;
        else lo_cnt <= lo_cnt + 8'h01;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_busy_len: assert property (
        $rose(busy_n_o) && !$past(rst_i) |-> lo_cnt == 14 * STEP_CYC)
        else $error("busy low length wrong");
    chk_no_restart: assert property (
        !busy_n_o |-> lo_cnt < 14 * STEP_CYC)
        else $error("conversion ran too long");
    chk_sample_inst: assert property (
        sample_hold_o == $fell(busy_n_o))
        else $error("sample pulse not at start");
    chk_result_load: assert property (
        $changed(result_o) && !$past(rst_i)
        |-> $past(busy_n_o) && !$past(busy_n_o, 2))
        else $error("result changed outside load");
    chk_flag_load: assert property (
        $changed(out_of_range_flag_o) && !$past(rst_i)
        |-> $past(busy_n_o) && !$past(busy_n_o, 2))
        else $error("flag changed outside load");
    chk_flag_neg: assert property (
        $rose(busy_n_o) ##1 result_o == 14'h2000 |-> out_of_range_flag_o)
        else $error("flag missing on most negative code");
    chk_range_map: assert property (
        $stable(range_select_lo_i) && $stable(range_select_hi_i) && !$past(rst_i)
        |-> range_code_o == {~range_select_lo_i, ~range_select_hi_i})
        else $error("range code wrong");
    chk_nap_level: assert property (
        !$past(rst_i) |-> nap_active_o == !$past(nap_shutdown_n_i))
        else $error("nap state wrong");
    chk_deep_level: assert property (
        !$past(rst_i) |-> deep_active_o == !$past(deep_shutdown_n_i))
        else $error("deep state wrong");
    chk_shut_idle: assert property (
        busy_n_o && !(nap_shutdown_n_i && deep_shutdown_n_i) |=> busy_n_o)
        else $error("conversion during shutdown");
    cover property ($fell(busy_n_o));
    cover property (out_of_range_flag_o && result_o == 14'h2000);
    cover property (!nap_shutdown_n_i && busy_n_o);
endmodule // sarcc_top_properties
bind sarcc_top sarcc_top_properties #(.STEP_CYC(STEP_CYC)) u_props (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .busy_n_o(busy_n_o), .sample_hold_o(sample_hold_o),
    .out_of_range_flag_o(out_of_range_flag_o), .range_select_lo_i(range_select_lo_i),
    .range_select_hi_i(range_select_hi_i), .nap_shutdown_n_i(nap_shutdown_n_i),
    .deep_shutdown_n_i(deep_shutdown_n_i), .nap_active_o(nap_active_o),
    .deep_active_o(deep_active_o), .result_o(result_o), .range_code_o(range_code_o));

// ==== testbench/sarcc_top_tb.sv ====
`timescale 1ns/1ns
module sarcc_top_tb;
    reg         clk = 0, rst = 1, st_n = 1, ovr = 0, lo = 1, hi = 1, nap_n = 1, slp_n = 1, stall = 0;
    reg  [13:0] tgt = 14'h0000;
    reg  [14:0] last = 15'h0000;
    wire        comp, rdy, busy_n, sh, nap_a, slp_a, full, fv, out_of_range_flag;
    wire [13:0] res, dac;
    wire [1:0]  rc;
    wire [14:0] fd;
    integer     n_fail = 0, compares = 0, i, j, k;
    always #5 clk = ~clk;
    sarcc_top dut (.sys_clk_i(clk), .rst_i(rst), .conversion_start_n_i(st_n),
        .comparator_high_i(comp), .overrange_detect_i(ovr), .range_select_lo_i(lo),
        .range_select_hi_i(hi), .nap_shutdown_n_i(nap_n), .deep_shutdown_n_i(slp_n),
        .result_ready_i(rdy), .busy_n_o(busy_n), .result_o(res), .out_of_range_flag_o(out_of_range_flag),
        .sample_hold_o(sh), .range_code_o(rc), .nap_active_o(nap_a), .deep_active_o(slp_a),
        .dac_trial_o(dac), .fifo_full_o(full), .fifo_data_o(fd), .fifo_valid_o(fv));
    sarcc_host_model host (.dac_trial_i(dac), .target_i(tgt), .stall_i(stall),
        .comp_o(comp), .ready_o(rdy));
    task chk(input [8*6:1] nm, input [14:0] e, input [14:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wbusy(input v);
        begin
            k = 0;
            while (busy_n !== v && k < 50) begin
                @(posedge clk);
                #1 k = k + 1;
            end
            if (k == 50) begin
                n_fail = n_fail + 1;
                results;
            end
        end
    endtask
    task conv(input [13:0] t, input o);
        begin
            @(posedge clk) tgt <= t;
            ovr <= o;
            cyc(10);
            st_n <= 0;
            wbusy(1'b0);
            // a second edge inside the conversion must be ignored
            @(posedge clk) st_n <= 1;
            @(posedge clk) st_n <= 0;
            wbusy(1'b1);
            cyc(2);
            #1 last = {(t == 14'h2000) | o, t};
            chk("result", last, {out_of_range_flag, res});
            for (i = 0; i < 15; i = i + 1) begin
                @(posedge clk);
                #1 chk("busy", 1'b1, busy_n);
            end
            @(posedge clk) st_n <= 1;
        end
    endtask
    initial begin
        cyc(12);
        rst <= 0;
        cyc(2);
        conv(14'h0000, 1'b0);
        conv(14'h1fff, 1'b0);
        conv(14'h2000, 1'b0);
        conv(14'h1555, 1'b1);
        conv(14'h3fff, 1'b0);
        $display("test convert done");
        for (j = 0; j < 2; j = j + 1) begin
            @(posedge clk) nap_n <= j[0];
            slp_n <= ~j[0];
            cyc(3);
            st_n <= 0;
            cyc(20);
            #1 chk("busy", 1'b1, busy_n);
            chk("acts", {~j[0], j[0]}, {nap_a, slp_a});
            chk("result", last, {out_of_range_flag, res});
            @(posedge clk) nap_n <= 1;
            slp_n <= 1;
            st_n <= 1;
            cyc(25);
        end
        $display("test shutdown done");
        for (j = 0; j < 4; j = j + 1) begin
            @(posedge clk) {lo, hi} <= j[1:0];
            cyc(3);
            #1 chk("range", 2'h3 - j[1:0], rc);
        end
        $display("test range done");
        stall <= 1;
        for (j = 0; j < 4; j = j + 1) conv(14'h0100 + j[13:0], 1'b0);
        cyc(3);
        st_n <= 0;
        cyc(20);
        #1 chk("full", 1'b1, full);
        chk("busy", 1'b1, busy_n);
        @(posedge clk) stall <= 0;
        for (j = 0; j < 4; j = j + 1) begin
            #1 chk("fifo", {1'b0, 14'h0100 + j[13:0]}, fd);
            @(posedge clk);
        end
        #1 chk("valid", 1'b0, fv);
        @(posedge clk) st_n <= 1;
        $display("test buffer done");
        results;
    end
endmodule // sarcc_top_tb
